// ===== mid_core.sv
// instruction decode, condition evaluation and flag update core
// assumes one decoded instruction per ins_valid cycle with its operands
// already fetched, and the stack byte at stk_addr presented on stk_rdata
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "mid_regs.svh"

module mid_core (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // instruction stream
    input wire logic ins_valid,
    input wire logic [7:0] ins_opcode,
    input wire logic [7:0] ins_dst,
    input wire logic [7:0] ins_src,
    input wire logic [15:0] ins_word,
    input wire logic [15:0] ins_pc,
    // stack memory
    input wire logic [7:0] stk_rdata,
    output logic [15:0] stk_addr,
    output logic [15:0] stk_waddr,
    output logic [7:0] stk_wdata,
    output logic stk_we,
    // results
    output logic [7:0] res_data,
    output logic res_we,
    output logic [15:0] word_data,
    output logic word_we,
    output logic [15:0] pc_next,
    output logic pc_load,
    output logic autoinc
);

    mid_pkg::mid_state_t s_r;
    mid_pkg::mid_state_t s_nxt;
    mid_pkg::mid_aluop_t alu_op;
    mid_pkg::mid_alu_t alu_out;
    logic [3:0] hi;
    logic [3:0] lo;
    logic fam;
    logic [15:0] wsum;

    // all checks below run on the core clock and sleep through reset
    default clocking cb_chk @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////
    // condition field evaluation, shared by relative and absolute jumps
    function automatic logic cond_true(input logic [3:0] cc, input mid_pkg::mid_flags_t f);
        logic sv;
        sv = f.s ^ f.v;
        case (cc)
            4'b1000: cond_true = 1'b1;
            4'b0000: cond_true = 1'b0;
            4'b0111: cond_true = f.c;
            4'b1111: cond_true = !f.c;
            4'b0110: cond_true = f.z;
            4'b1110: cond_true = !f.z;
            4'b0101: cond_true = f.s;
            4'b1101: cond_true = !f.s;
            4'b0100: cond_true = f.v;
            4'b1100: cond_true = !f.v;
            4'b1001: cond_true = !sv;
            4'b0001: cond_true = sv;
            4'b1010: cond_true = !(f.z | sv);
            4'b0010: cond_true = f.z | sv;
            4'b1011: cond_true = !f.c && !f.z;
            4'b0011: cond_true = f.c | f.z;
            default: cond_true = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // operation select; two-operand families share lower nibbles 2 to 7
    assign hi = ins_opcode[7:4];
    assign lo = ins_opcode[3:0];
    assign fam = (lo >= 4'h2) && (lo <= 4'h7) && (hi <= 4'h5 || hi == 4'ha || hi == 4'hb);

    always_comb
    begin
        alu_op = mid_pkg::MID_OP_NONE;
        if (fam)
        begin
            case (hi)
                4'h0: alu_op = mid_pkg::MID_OP_ADD;
                4'h1: alu_op = mid_pkg::MID_OP_ADC;
                4'h2: alu_op = mid_pkg::MID_OP_SUB;
                4'h3: alu_op = mid_pkg::MID_OP_SBC;
                4'h4: alu_op = mid_pkg::MID_OP_OR;
                4'h5: alu_op = mid_pkg::MID_OP_AND;
                4'ha: alu_op = mid_pkg::MID_OP_CP;
                4'hb: alu_op = mid_pkg::MID_OP_XOR;
                default: alu_op = mid_pkg::MID_OP_NONE;
            endcase
        end
        else if (ins_opcode == 8'h60 || ins_opcode == 8'h61)
            alu_op = mid_pkg::MID_OP_COM;
        else if (ins_opcode == 8'h20 || ins_opcode == 8'h21 || lo == `MID_LO_INC)
            alu_op = mid_pkg::MID_OP_INC;
    end

    mid_alu u_alu (
        .op(alu_op),
        .a(ins_dst),
        .b(ins_src),
        .cin(s_r.flags.c),
        .out(alu_out)
    );

    // word increment or decrement on a register pair
    assign wsum = (hi == 4'h8) ? ins_word - 16'h0001 : ins_word + 16'h0001;

    ////////////////////////////////////////////////////////////////////////
    // next state: register port first, then an instruction in the same
    // cycle overrides it, so software cannot tear a flag update
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        s_nxt.res_we = 1'b0;
        s_nxt.word_we = 1'b0;
        s_nxt.pc_load = 1'b0;
        s_nxt.stk_we = 1'b0;
        s_nxt.autoinc = 1'b0;
        // register port; unmapped reads return zero
        if (reg_rd)
        begin
            case (reg_addr)
                `MID_OFF_IMASK: s_nxt.rdata = s_r.imask;
                `MID_OFF_FLAGS: s_nxt.rdata = s_r.flags;
                `MID_OFF_WPTR: s_nxt.rdata = s_r.wptr;
                `MID_OFF_SP_HI: s_nxt.rdata = s_r.sp[15:8];
                `MID_OFF_SP_LO: s_nxt.rdata = s_r.sp[7:0];
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        if (reg_wr)
        begin
            case (reg_addr)
                `MID_OFF_IMASK: s_nxt.imask = reg_wdata;
                `MID_OFF_FLAGS: s_nxt.flags = reg_wdata;
                `MID_OFF_WPTR: s_nxt.wptr = reg_wdata;
                `MID_OFF_SP_HI: s_nxt.sp[15:8] = reg_wdata;
                `MID_OFF_SP_LO: s_nxt.sp[7:0] = reg_wdata;
                default: s_nxt.rdata = s_nxt.rdata;
            endcase
        end
        if (ins_valid && fam)
        begin
            // compare and the arithmetic families touch carry; every family writes overflow
            s_nxt.flags.z = alu_out.z;
            s_nxt.flags.s = alu_out.s;
            s_nxt.flags.v = alu_out.v; // logic forms give zero
            if (hi <= 4'h3 || hi == 4'ha)
                s_nxt.flags.c = alu_out.c;
            if (hi <= 4'h3)
            begin
                s_nxt.flags.h = alu_out.h;
                s_nxt.flags.d = hi[1]; // clear for add, set for subtract
            end
            s_nxt.res = alu_out.res;
            s_nxt.res_we = (hi != 4'ha); // compare leaves destination
        end
        else if (ins_valid)
        begin
            case (ins_opcode)
                8'h31: s_nxt.wptr = ins_src;
                8'h8f: s_nxt.imask[`MID_IMASK_GLOBAL] = 1'b0;
                8'h9f: s_nxt.imask[`MID_IMASK_GLOBAL] = 1'b1;
                8'hbf:
                begin
                    // return pops flags, then the saved program counter
                    s_nxt.imask[`MID_IMASK_GLOBAL] = 1'b1;
                    s_nxt.flags = stk_rdata;
                    s_nxt.sp = s_r.sp + 16'h0003;
                    s_nxt.pc = ins_word;
                    s_nxt.pc_load = 1'b1;
                end
                8'h60, 8'h61, 8'h20, 8'h21:
                begin
                    // carry held for complement and increment
                    s_nxt.flags.z = alu_out.z;
                    s_nxt.flags.s = alu_out.s;
                    s_nxt.flags.v = alu_out.v;
                    s_nxt.res = alu_out.res;
                    s_nxt.res_we = 1'b1;
                end
                8'h80, 8'h81, 8'ha0, 8'ha1:
                begin
                    s_nxt.flags.z = (wsum == 16'h0000);
                    s_nxt.flags.s = wsum[15];
                    s_nxt.flags.v = (hi == 4'h8) ? (wsum == 16'h7fff) : (wsum == 16'h8000);
                    s_nxt.word = wsum;
                    s_nxt.word_we = 1'b1;
                end
                8'h50, 8'h51:
                begin
                    s_nxt.res = stk_rdata;
                    s_nxt.res_we = 1'b1;
                    s_nxt.sp = s_r.sp + 16'h0001;
                end
                8'h70, 8'h71:
                begin
                    s_nxt.sp = s_r.sp - 16'h0001;
                    s_nxt.stk_waddr = s_r.sp - 16'h0001;
                    s_nxt.stk_wdata = ins_src;
                    s_nxt.stk_we = 1'b1;
                end
                8'hc3, 8'hd3, 8'h83, 8'h93:
                begin
                    // moved byte travels outside; here only the pointers step
                    s_nxt.res = ins_dst + 8'h01;
                    s_nxt.res_we = 1'b1;
                    s_nxt.word = ins_word + 16'h0001;
                    s_nxt.word_we = 1'b1;
                    s_nxt.autoinc = 1'b1;
                end
                8'hcf: s_nxt.flags.c = 1'b0;
                8'hdf: s_nxt.flags.c = 1'b1;
                8'hef: s_nxt.flags.c = !s_r.flags.c;
                default:
                begin
                    if (lo == `MID_LO_INC)
                    begin
                        s_nxt.flags.z = alu_out.z;
                        s_nxt.flags.s = alu_out.s;
                        s_nxt.flags.v = alu_out.v;
                        s_nxt.res = alu_out.res;
                        s_nxt.res_we = 1'b1;
                    end
                    else if (lo == `MID_LO_JR)
                    begin
                        // displacement is a signed byte, so reach is +127/-128
                        s_nxt.pc = ins_pc + {{8{ins_src[7]}}, ins_src};
                        s_nxt.pc_load = cond_true(hi, s_r.flags);
                    end
                    else if (lo == `MID_LO_JP)
                    begin
                        s_nxt.pc = ins_word;
                        s_nxt.pc_load = cond_true(hi, s_r.flags);
                    end
                    // anything else is taken as no-operation
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_r <= '0;
            s_r.imask <= `MID_RST_IMASK;
            s_r.flags <= `MID_RST_FLAGS;
            s_r.wptr <= `MID_RST_WPTR;
            s_r.sp <= `MID_RST_SP;
        end
        else
            s_r <= s_nxt;
    end

    // outputs come straight from the state flops
    assign reg_rdata = s_r.rdata;
    assign stk_addr = s_r.sp;
    assign stk_waddr = s_r.stk_waddr;
    assign stk_wdata = s_r.stk_wdata;
    assign stk_we = s_r.stk_we;
    assign res_data = s_r.res;
    assign res_we = s_r.res_we;
    assign word_data = s_r.word;
    assign word_we = s_r.word_we;
    assign pc_next = s_r.pc;
    assign pc_load = s_r.pc_load;
    assign autoinc = s_r.autoinc;

    ////////////////////////////////////////////////////////////////////////
    // checks on the decode behaviour

    AST_MASK_DISABLE: assert property (
        ins_valid && ins_opcode == 8'h8f |=> !s_r.imask[7])
        else $error("disable left global enable set");
    AST_MASK_ENABLE: assert property (
        ins_valid && (ins_opcode == 8'h9f || ins_opcode == 8'hbf) |=> s_r.imask[7])
        else $error("enable or return left global enable clear");
    AST_PTR_LOAD: assert property (
        ins_valid && ins_opcode == 8'h31 |=> s_r.wptr == $past(ins_src))
        else $error("set-pointer did not load immediate");
    AST_JR_NEVER: assert property (
        ins_valid && ins_opcode == 8'h0b |=> !pc_load)
        else $error("never-true jump was taken");
    AST_JR_ALWAYS: assert property (
        ins_valid && ins_opcode == 8'h8b |=> pc_load
        && pc_next == $past(ins_pc) + {{8{$past(ins_src[7])}}, $past(ins_src)})
        else $error("always-true jump target wrong");
    AST_JR_LT: assert property (
        ins_valid && ins_opcode == 8'h1b |=> pc_load == $past(s_r.flags.s ^ s_r.flags.v))
        else $error("signed less-than misjudged");
    AST_JR_ULE: assert property (
        ins_valid && ins_opcode == 8'h3b |=> pc_load == $past(s_r.flags.c | s_r.flags.z))
        else $error("unsigned less-or-equal misjudged");
    AST_PUSH_SP: assert property (
        ins_valid && ins_opcode == 8'h70 |=> stk_we && stk_waddr == $past(s_r.sp) - 16'h0001
        && s_r.sp == stk_waddr)
        else $error("push did not pre-decrement stack");
    AST_POP_SP: assert property (
        ins_valid && ins_opcode == 8'h50 |=> res_we && res_data == $past(stk_rdata)
        && s_r.sp == $past(s_r.sp) + 16'h0001)
        else $error("pop data or stack step wrong");
    AST_CP_KEEPS: assert property (
        ins_valid && ins_opcode == 8'ha2 && !reg_wr |=> !res_we
        && $stable(s_r.flags.d) && $stable(s_r.flags.h))
        else $error("compare wrote destination or touched D/H");
    AST_SBC_DSET: assert property (
        ins_valid && ins_opcode == 8'h32 |=> s_r.flags.d)
        else $error("subtract-with-borrow left D clear");
    AST_ADD_DCLR: assert property (
        ins_valid && (hi == 4'h0 || hi == 4'h1) && fam |=> !s_r.flags.d)
        else $error("add left D set");
    AST_LOGIC_FLAGS: assert property (
        ins_valid && ins_opcode == 8'h52 && !reg_wr |=> !s_r.flags.v && $stable(s_r.flags.c))
        else $error("logic form changed carry or kept overflow");
    AST_COM_RES: assert property (
        ins_valid && ins_opcode == 8'h60 |=> res_data == ~$past(ins_dst) && !s_r.flags.v)
        else $error("complement result wrong");
    AST_INC_CARRY: assert property (
        ins_valid && ins_opcode == 8'h20 && !reg_wr |=> $stable(s_r.flags.c)
        && res_data == $past(ins_dst) + 8'h01)
        else $error("increment touched carry");
    AST_AUTOINC: assert property (
        ins_valid && ins_opcode == 8'hc3 |=> autoinc && res_data == $past(ins_dst) + 8'h01
        && word_data == $past(ins_word) + 16'h0001)
        else $error("auto-increment pointers did not step");

endmodule

`default_nettype wire

// ===== mid_regs.svh
// control register offsets, field positions, reset values
// assumes an 8-bit register-file address space shared with the core
`ifndef MID_REGS_SVH
`define MID_REGS_SVH

// control register offsets in the register file
`define MID_OFF_IMASK 8'hfb
`define MID_OFF_FLAGS 8'hfc
`define MID_OFF_WPTR 8'hfd
`define MID_OFF_SP_HI 8'hfe
`define MID_OFF_SP_LO 8'hff

// field positions
`define MID_IMASK_GLOBAL 3'd7
`define MID_LO_JR 4'hb
`define MID_LO_JP 4'hd
`define MID_LO_INC 4'he

// reset values
`define MID_RST_IMASK 8'h00
`define MID_RST_FLAGS 8'h00
`define MID_RST_WPTR 8'h00
`define MID_RST_SP 16'h0000

`endif

// ===== mid_pkg.sv
// types shared by the decode/flag core and its arithmetic unit
// assumes mid_regs.svh carries the numeric constants
package mid_pkg;

    // status flag byte, carry in the top bit
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
        logic [1:0] user;
    } mid_flags_t;

    typedef enum logic [3:0] {
        MID_OP_NONE, MID_OP_ADD, MID_OP_ADC, MID_OP_SUB, MID_OP_SBC, MID_OP_CP,
        MID_OP_OR, MID_OP_AND, MID_OP_XOR, MID_OP_COM, MID_OP_INC
    } mid_aluop_t;

    // byte result and the flags it produces
    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic z;
        logic s;
        logic v;
        logic h;
    } mid_alu_t;

    // whole state of the decode core
    typedef struct packed {
        logic [7:0] imask;
        mid_flags_t flags;
        logic [7:0] wptr;
        logic [15:0] sp;
        logic [7:0] rdata;
        logic [7:0] res;
        logic res_we;
        logic [15:0] word;
        logic word_we;
        logic [15:0] pc;
        logic pc_load;
        logic [7:0] stk_wdata;
        logic [15:0] stk_waddr;
        logic stk_we;
        logic autoinc;
    } mid_state_t;

endpackage

// ===== mid_alu.sv
// byte arithmetic and logic unit with flag generation
// assumes the caller selects the operation and passes the incoming carry
`timescale 1ns/1ns
`default_nettype none

module mid_alu (
    // operation select
    input wire mid_pkg::mid_aluop_t op,
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    // result and flags
    output mid_pkg::mid_alu_t out
);

    logic [8:0] wide;
    logic [4:0] nib;
    logic cb;

    ////////////////////////////////////////////////////////////////////////
    // one adder/subtractor; borrow shows as carry for the subtract forms
    always_comb
    begin
        cb = (op == mid_pkg::MID_OP_ADC || op == mid_pkg::MID_OP_SBC) ? cin : 1'b0;
        wide = {1'b0, a} + {1'b0, b} + {8'h00, cb};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cb};
        out = '0;
        case (op)
            mid_pkg::MID_OP_ADD, mid_pkg::MID_OP_ADC:
            begin
                out.res = wide[7:0];
                out.c = wide[8];
                out.h = nib[4];
                out.v = (a[7] == b[7]) && (wide[7] != a[7]);
            end
            mid_pkg::MID_OP_SUB, mid_pkg::MID_OP_SBC, mid_pkg::MID_OP_CP:
            begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, cb};
                nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cb};
                out.res = wide[7:0];
                out.c = wide[8]; // borrow out
                out.h = nib[4];
                out.v = (a[7] != b[7]) && (wide[7] != a[7]);
            end
            mid_pkg::MID_OP_OR: out.res = a | b;
            mid_pkg::MID_OP_AND: out.res = a & b;
            mid_pkg::MID_OP_XOR: out.res = a ^ b;
            mid_pkg::MID_OP_COM: out.res = ~a;
            mid_pkg::MID_OP_INC:
            begin
                out.res = a + 8'h01;
                out.v = (a == 8'h7f);
            end
            default: out.res = a;
        endcase
        out.z = (out.res == 8'h00);
        out.s = out.res[7];
    end

endmodule

`default_nettype wire

// ===== test_mid_core.sv
// self-checking bench for the decode, condition and flag core
// assumes mid_regs.svh offsets, a 100 MHz clock and one-cycle answers
`timescale 1ns/1ns
`default_nettype none
`include "mid_regs.svh"

module test_mid_core;
    logic clk;
    logic nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ins_valid = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ins_opcode = 8'h00;
    logic [7:0] ins_dst = 8'h00, ins_src = 8'h00, stk_rdata = 8'h00;
    logic [15:0] ins_word = 16'h0000, ins_pc = 16'h0000;
    logic [7:0] reg_rdata, stk_wdata, res_data, op, f, a, b, v;
    logic [15:0] stk_addr, stk_waddr, word_data, pc_next, w, r, e;
    logic stk_we, res_we, word_we, pc_load, autoinc;
    logic [3:0] lo;
    logic [39:0] rv;
    logic [31:0] st = 32'h0000_003f;
    int k;
    int n_fail = 0;
    int tests_run = 0;
    logic [3:0] fam [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'h4, 4'h5, 4'hb};
    logic [31:0] cor [7] = '{32'h0400_7f01, 32'h1480_ff00, 32'h3680_8000, 32'ha200_5555,
        32'h3200_1234, 32'h5280_f00f, 32'h2000_7f00};
    logic [15:0] wc [5] = '{16'hffff, 16'h7fff, 16'h8000, 16'h0000, 16'h0001};
    logic [7:0] ai [4] = '{8'hc3, 8'hd3, 8'h83, 8'h93};

    mid_core i_mid_core (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ins_valid(ins_valid), .ins_opcode(ins_opcode), .ins_dst(ins_dst),
        .ins_src(ins_src), .ins_word(ins_word), .ins_pc(ins_pc), .stk_rdata(stk_rdata),
        .stk_addr(stk_addr), .stk_waddr(stk_waddr), .stk_wdata(stk_wdata), .stk_we(stk_we),
        .res_data(res_data), .res_we(res_we), .word_data(word_data), .word_we(word_we),
        .pc_next(pc_next), .pc_load(pc_load), .autoinc(autoinc));

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////
    // xorshift source, fixed start so every run repeats
    function automatic logic [7:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st[7:0];
    endfunction

    // branch condition from the flag byte, C Z S V in the top bits
    function automatic logic cond(input logic [3:0] cc, input logic [7:0] g);
        logic [7:0] t;
        t = {g[7], g[6], g[5], g[4], g[7] | g[6], g[6] | (g[5] ^ g[4]), g[5] ^ g[4], 1'b0};
        return t[cc[2:0]] ^ cc[3];
    endfunction

    // expected byte result and flag byte; carry is a borrow on subtracts
    function automatic logic [15:0] alu_exp(input logic [7:0] o, input logic [7:0] g,
        input logic [7:0] x, input logic [7:0] y);
        logic [8:0] q;
        logic [4:0] h;
        logic cy;
        logic sub;
        sub = o[7:4] == 4'h2 || o[7:4] == 4'h3 || o[7:4] == 4'ha;
        cy = g[7] & o[4];
        q = sub ? {1'b0, x} - y - cy : {1'b0, x} + y + cy;
        h = sub ? {1'b0, x[3:0]} - y[3:0] - cy : {1'b0, x[3:0]} + y[3:0] + cy;
        g[4] = (x[7] ^ q[7]) & ~(x[7] ^ y[7] ^ sub);
        if (o[3:0] == 4'he || o[7:1] == 7'h10)
        begin
            q = {1'b0, x} + 9'h001;
            g[4] = q[7:0] == 8'h80;
        end
        else if (o[7:4] < 4'h4 || o[7:4] == 4'ha)
        begin
            g[7] = q[8];
            g[3] = o[7:4] == 4'ha ? g[3] : sub;
            g[2] = o[7:4] == 4'ha ? g[2] : h[4];
        end
        else
        begin
            q[7:0] = o[7:4] == 4'h4 ? x | y : o[7:4] == 4'h5 ? x & y : o[7:4] == 4'hb ? x ^ y : ~x;
            g[4] = 1'b0;
        end
        g[6] = q[7:0] == 8'h00;
        g[5] = q[7];
        return {q[7:0], g};
    endfunction

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // register port cycles; read data is taken the cycle after the strobe
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // one instruction; its answer is settled 1 ns after the next edge
    task automatic ins(input logic [7:0] o, input logic [7:0] d = 8'h00,
        input logic [7:0] s = 8'h00, input logic [15:0] wd = 16'h0000,
        input logic [15:0] p = 16'h0000, input logic [7:0] sk = 8'h00);
        @(posedge clk);
        ins_valid <= 1'b1;
        ins_opcode <= o;
        ins_dst <= d;
        ins_src <= s;
        ins_word <= wd;
        ins_pc <= p;
        stk_rdata <= sk;
        @(posedge clk);
        ins_valid <= 1'b0;
        #1;
    endtask

    // hang guard, far beyond the roughly 1500 cycles the tests need
    initial
    begin
        #500000;
        n_fail++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rv = {`MID_RST_IMASK, `MID_RST_FLAGS, `MID_RST_WPTR, `MID_RST_SP};
        for (int i = 0; i < 5; i++)
        begin
            rd(8'hfb + 8'(i), v);
            check(v, rv[39 - 8 * i -: 8]);
        end
        wr(8'h10, 8'h5a);
        rd(8'h10, v);
        check(v, 8'h00);
        wr(`MID_OFF_IMASK, 8'h15);
        ins(8'h9f);
        rd(`MID_OFF_IMASK, v);
        check(v, 8'h95);
        ins(8'h8f);
        rd(`MID_OFF_IMASK, v);
        check(v, 8'h15);
        ins(8'h31, 8'h00, 8'h40);
        rd(`MID_OFF_WPTR, v);
        check(v, 8'h40);
        @(posedge clk);
        #1 check(reg_rdata, 8'h00);
        // return restores flags, target and mask; pointer crosses a byte
        wr(`MID_OFF_SP_HI, 8'h01);
        wr(`MID_OFF_SP_LO, 8'hfe);
        ins(8'hbf, 8'h00, 8'h00, 16'h1234, 16'h0000, 8'ha5);
        check({pc_load, pc_next}, 17'h1_1234);
        rd(`MID_OFF_IMASK, v);
        check(v, 8'h95);
        rd(`MID_OFF_FLAGS, v);
        check(v, 8'ha5);
        rd(`MID_OFF_SP_HI, v);
        check(v, 8'h02);
        rd(`MID_OFF_SP_LO, v);
        check(v, 8'h01);
        // every condition code, displacement limits first
        for (int c = 0; c < 64; c++)
        begin
            f = rnd();
            b = c < 16 ? 8'h7f : c < 32 ? 8'h80 : rnd();
            w = {rnd(), rnd()};
            r = c >= 48 ? w : w + {{8{b[7]}}, b};
            wr(`MID_OFF_FLAGS, f);
            // last quarter uses the absolute form, target from the word operand
            ins({4'(c), c >= 48 ? 4'hd : 4'hb}, 8'h00, b, w, w);
            check(pc_load, cond(4'(c), f));
            if (pc_load === 1'b1)
                check(pc_next, r);
        end
        // byte operations, corner cases then random
        for (int i = 0; i < 160; i++)
        begin
            {f, a, b} = {rnd(), rnd(), rnd()};
            k = rnd() % 10;
            lo = 4'h2 + 4'(rnd() % 6);
            op = k == 8 ? {7'h30, b[0]} : k == 9 ? (b[1] ? {7'h10, b[0]} : {a[3:0], 4'he})
                : {fam[k], lo};
            if (i < 7)
                {op, f, a, b} = cor[i];
            wr(`MID_OFF_FLAGS, f);
            ins(op, a, b);
            e = alu_exp(op, f, a, b);
            check(res_we, op[7:4] != 4'ha || op[3:0] == 4'he);
            if (res_we === 1'b1)
                check(res_data, e[15:8]);
            rd(`MID_OFF_FLAGS, v);
            check(v, e[7:0]);
        end
        // word step up and down around the sign and zero boundaries
        for (int i = 0; i < 16; i++)
        begin
            w = i < 10 ? wc[i / 2] : {rnd(), rnd()};
            f = rnd();
            r = i[0] ? w + 16'h0001 : w - 16'h0001;
            wr(`MID_OFF_FLAGS, f);
            ins({i[0] ? 4'ha : 4'h8, 3'b000, f[0]}, 8'h00, 8'h00, w);
            check({word_we, word_data}, {1'b1, r});
            rd(`MID_OFF_FLAGS, v);
            e = {8'h00, f[7], r == 16'h0000, r[15], r == (i[0] ? 16'h8000 : 16'h7fff), f[3:0]};
            check(v, e[7:0]);
        end
        // push then pop, first pass wraps through address zero
        for (int i = 0; i < 6; i++)
        begin
            w = i == 0 ? 16'h0000 : {rnd(), rnd()};
            {f, b, a} = {rnd(), rnd(), rnd()};
            r = w - 16'h0001;
            wr(`MID_OFF_FLAGS, f);
            wr(`MID_OFF_SP_HI, w[15:8]);
            wr(`MID_OFF_SP_LO, w[7:0]);
            ins(8'h70, 8'h00, b);
            check({stk_we, stk_waddr, stk_wdata, stk_addr}, {1'b1, r, b, r});
            ins({7'h28, i[0]}, 8'h00, 8'h00, 16'h0000, 16'h0000, a);
            check({res_we, res_data, stk_addr}, {1'b1, a, w});
            rd(`MID_OFF_FLAGS, v);
            check(v, f);
        end
        // auto-increment loads, all four forms
        for (int i = 0; i < 4; i++)
        begin
            a = i == 0 ? 8'hff : rnd();
            w = i == 0 ? 16'hffff : {rnd(), rnd()};
            ins(ai[i], a, 8'h00, w);
            check({autoinc, res_data, word_data}, {1'b1, a + 8'h01, w + 16'h0001});
        end
        // blank opcode leaves everything alone
        f = rnd();
        wr(`MID_OFF_FLAGS, f);
        ins(8'h84, rnd(), rnd(), 16'hffff, 16'hffff);
        check({res_we, word_we, stk_we, pc_load, autoinc}, 5'h00);
        rd(`MID_OFF_FLAGS, v);
        check(v, f);
        // carry clear, set and invert leave the other flags alone
        for (int i = 0; i < 3; i++)
        begin
            ins(8'hcf + 8'(16 * i));
            rd(`MID_OFF_FLAGS, v);
            check(v, {i == 1, f[6:0]});
        end
        print_verdict();
    end
endmodule
`default_nettype wire
